// ---- design/stc_defines.svh ----
/*
  Offsets, field positions, reset values and timing counts of the
  sixteen-bit timer/counter.
  Assumes it is included by bare name from the package and the design.
*/
`ifndef STC_DEFINES_SVH
`define STC_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets on the plain register port.
// ----------------------------------------------------------------------
`define STC_ADDR_W          3
`define STC_OFS_COUNT_LO    3'h0
`define STC_OFS_COUNT_HI    3'h1
`define STC_OFS_CTRL        3'h2
`define STC_OFS_GATE        3'h3

// ----------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------
`define STC_GATE_LEVEL_BIT  2
`define STC_GATE_WR_MASK    8'hC1
`define STC_CTRL_WR_MASK    8'hFD

// ----------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------
`define STC_CTRL_RST        8'h00
`define STC_GATE_RST        8'h00
`define STC_COUNT_RST       16'h0000

// ----------------------------------------------------------------------
// Timing.
// ----------------------------------------------------------------------
`define STC_CLK_PERIOD_NS   40
`define STC_INSTR_DIV       4

`endif

// ---- design/stc_pkg.sv ----
/*
  Types shared by the timer/counter design: register layouts, the
  register port request and the clock-select codes.
  Assumes the defines header sits beside it.
*/
`include "stc_defines.svh"

package stc_pkg;

  // Count clock selection codes.
  typedef enum logic [1:0] {
    STC_CS_INSTR = 2'h0,
    STC_CS_SYS   = 2'h1,
    STC_CS_PIN   = 2'h2,
    STC_CS_SLOW  = 2'h3
  } stc_clk_sel_e;

  // Layout of counter_control_reg.
  typedef struct packed {
    stc_clk_sel_e count_clock_select;
    logic [1:0]   prescale;
    logic         secondary_osc_enable;
    logic         async_select;
    logic         unused;
    logic         counter_run_bit;
  } stc_ctrl_s;

  // Layout of gate_control_reg.
  typedef struct packed {
    logic       gate_enable_bit;
    logic       gate_polarity;
    logic [2:0] unused_hi;
    logic       gate_level;
    logic       unused_lo;
    logic       gate_source;
  } stc_gate_s;

  // One register port request.
  typedef struct packed {
    logic [`STC_ADDR_W-1:0] addr;
    logic [7:0]             wdata;
    logic                   wr;
    logic                   rd;
  } stc_bus_req_s;

endpackage : stc_pkg

// ---- design/stc_edge_sync.sv ----
/*
  Two-stage synchroniser with edge detection for one asynchronous input.
  Assumes clk_sys_in is the only clock and resetn_in is asynchronous.
*/
`timescale 1ns/1ps

module stc_edge_sync (
  input  wire logic clk_sys_in,
  input  wire logic resetn_in,
  input  wire logic async_in,
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  // The first stage is read by the second stage only.
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end
    else
    begin
      meta_r <= async_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // Edge pulses last one cycle.
  assign level_out = sync_r;
  assign rise_out  = sync_r & ~prev_r;
  assign fall_out  = ~sync_r & prev_r;

endmodule : stc_edge_sync

// ---- design/stc_timer.sv ----
/*
  Sixteen-bit timer/counter with byte-wide register access, four count
  clock sources, a prescaler, a run bit and a count gate.
  Assumes one 25 MHz clock, an asynchronous active-low reset, and that
  the pins and the comparator outputs are asynchronous to the clock.
*/
`timescale 1ns/1ps

`include "stc_defines.svh"

module stc_timer #(
  parameter int COUNT_W = 16,
  parameter int PRESC_W = 2
) (
  input  wire logic                 clk_sys_in,
  input  wire logic                 resetn_in,
  input  wire stc_pkg::stc_bus_req_s bus_req_in,
  output logic [7:0]                rdata_out,
  input  wire logic                 external_count_input_in,
  input  wire logic                 gate_input_pin_in,
  input  wire logic                 comparator_in,
  input  wire logic                 slow_internal_oscillator_in,
  output logic [COUNT_W-1:0]        count_out,
  output logic                      overflow_out,
  output logic                      counting_out
);

  import stc_pkg::*;

  // ----------------------------------------------------------------------
  // Parameter checks.
  // ----------------------------------------------------------------------
  if (COUNT_W != 16)
  begin : g_bad_count_w
    $error("COUNT_W must be 16 for the byte pair access");
  end
  if (PRESC_W != 2)
  begin : g_bad_presc_w
    $error("PRESC_W must match the two-bit prescale field");
  end

  localparam int DIV_W = $clog2(`STC_INSTR_DIV);
  localparam int PCNT_W = (1 << PRESC_W) - 1;

  // Falling-edge arming states for counter mode.
  typedef enum logic [2:0] {
    ST_OFF   = 3'b001,
    ST_WAIT  = 3'b010,
    ST_ARMED = 3'b100
  } stc_arm_e;

  // ----------------------------------------------------------------------
  // Storage.
  // ----------------------------------------------------------------------
  logic [COUNT_W-1:0] count_r;
  logic [COUNT_W-1:0] count_nxt;
  logic [7:0]         ctrl_r;
  logic [7:0]         gate_r;
  logic [7:0]         rdata_r;
  logic [7:0]         rdata_nxt;
  logic [DIV_W-1:0]   div_r;
  logic [PCNT_W-1:0]  presc_r;
  logic [PCNT_W-1:0]  presc_nxt;
  logic               pin_rise_d_r;
  logic               ovf_r;
  stc_arm_e           arm_r;
  stc_arm_e           arm_nxt;

  // ----------------------------------------------------------------------
  // Input synchronisers.
  // ----------------------------------------------------------------------
  logic pin_level;
  logic pin_rise;
  logic pin_fall;
  logic gpin_level;
  logic cmp_level;
  logic slow_rise;

  // External count pin.
  stc_edge_sync u_pin_sync (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .async_in   (external_count_input_in),
    .level_out  (pin_level),
    .rise_out   (pin_rise),
    .fall_out   (pin_fall)
  );

  // Gate pin.
  stc_edge_sync u_gate_sync (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .async_in   (gate_input_pin_in),
    .level_out  (gpin_level),
    .rise_out   (),
    .fall_out   ()
  );

  // Comparator output used as a gate source.
  stc_edge_sync u_cmp_sync (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .async_in   (comparator_in),
    .level_out  (cmp_level),
    .rise_out   (),
    .fall_out   ()
  );

  // Slow internal oscillator, counted on its rising edges.
  stc_edge_sync u_slow_sync (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .async_in   (slow_internal_oscillator_in),
    .level_out  (),
    .rise_out   (slow_rise),
    .fall_out   ()
  );

  // ----------------------------------------------------------------------
  // Register decode.
  // ----------------------------------------------------------------------
  stc_ctrl_s ctrl;
  stc_gate_s gate;
  wire       wr_lo   = bus_req_in.wr && (bus_req_in.addr == `STC_OFS_COUNT_LO);
  wire       wr_hi   = bus_req_in.wr && (bus_req_in.addr == `STC_OFS_COUNT_HI);
  wire       wr_ctrl = bus_req_in.wr && (bus_req_in.addr == `STC_OFS_CTRL);
  wire       wr_gate = bus_req_in.wr && (bus_req_in.addr == `STC_OFS_GATE);
  wire       wr_cnt  = wr_lo | wr_hi;

  // The secondary oscillator bit is stored but the selector never looks at it.
  assign ctrl = stc_ctrl_s'(ctrl_r);
  assign gate = stc_gate_s'(gate_r);

  // ----------------------------------------------------------------------
  // Enable and gate.
  // ----------------------------------------------------------------------
  wire gate_src  = gate.gate_source ? cmp_level : gpin_level;
  wire gate_open = gate_src ^ gate.gate_polarity;
  wire run       = ctrl.counter_run_bit;

  // Off, always on, or counting only while the gate is open.
  wire count_en  = run & (~gate.gate_enable_bit | gate_open);

  // ----------------------------------------------------------------------
  // Count clock sources.
  // ----------------------------------------------------------------------
  wire instr_tick = (div_r == DIV_W'(`STC_INSTR_DIV - 1));
  wire pin_mode   = (ctrl.count_clock_select == STC_CS_PIN);

  // Synchronised mode takes the edge one aligning stage later.
  wire pin_edge   = ctrl.async_select ? pin_rise : pin_rise_d_r;

  // A pin rising edge counts only once a falling edge has armed it.
  wire pin_tick   = pin_edge & (arm_r == ST_ARMED);

  // Source tick picked by the two-bit selector.
  logic src_tick;
  always_comb
  begin
    case (ctrl.count_clock_select)
      STC_CS_SLOW:  src_tick = slow_rise;
      STC_CS_PIN:   src_tick = pin_tick;
      STC_CS_SYS:   src_tick = 1'b1;
      STC_CS_INSTR: src_tick = instr_tick;
      default:      src_tick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // Prescaler.
  // ----------------------------------------------------------------------
  wire [PCNT_W-1:0] presc_top = PCNT_W'((1 << ctrl.prescale) - 1);
  wire              gated_tick = src_tick & count_en;
  wire              presc_wrap = gated_tick & (presc_r >= presc_top);
  wire              inc        = presc_wrap;

  // Prescaler steps on each gated tick and restarts on wrap or count write.
  always_comb
  begin
    presc_nxt = presc_r;
    if (wr_cnt || !run)
      presc_nxt = '0;
    else if (presc_wrap)
      presc_nxt = '0;
    else if (gated_tick)
      presc_nxt = presc_r + PCNT_W'(1);
  end

  // ----------------------------------------------------------------------
  // Counter next value.
  // ----------------------------------------------------------------------
  wire [COUNT_W-1:0] count_inc = count_r + COUNT_W'(1);
  wire               wraps     = inc & (&count_r);

  // A byte write replaces its half at once and wins over an increment.
  always_comb
  begin
    count_nxt = count_r;
    if (wr_lo)
      count_nxt = {count_r[15:8], bus_req_in.wdata};
    else if (wr_hi)
      count_nxt = {bus_req_in.wdata, count_r[7:0]};
    else if (inc)
      count_nxt = count_inc;
  end

  // ----------------------------------------------------------------------
  // Falling-edge arming for counter mode.
  // ----------------------------------------------------------------------
  // Disable clears the arming and wins; a falling edge wins over a write.
  always_comb
  begin
    arm_nxt = arm_r;
    case (arm_r)
      ST_OFF:
        if (run && pin_fall)
          arm_nxt = ST_ARMED;
        else if (run)
          arm_nxt = ST_WAIT;
      ST_WAIT:
        if (!run)
          arm_nxt = ST_OFF;
        else if (pin_fall)
          arm_nxt = ST_ARMED;
      ST_ARMED:
        if (!run)
          arm_nxt = ST_OFF;
        else if (wr_cnt && !pin_fall)
          arm_nxt = ST_WAIT;
      default:
        arm_nxt = ST_OFF;
    endcase
  end

  // ----------------------------------------------------------------------
  // Read data.
  // ----------------------------------------------------------------------
  stc_gate_s gate_rd;
  always_comb
  begin
    gate_rd            = gate;
    gate_rd.unused_hi  = 3'h0;
    gate_rd.unused_lo  = 1'b0;
    gate_rd.gate_level = gate_src;
  end

  // Unmapped offsets read as zero.
  always_comb
  begin
    rdata_nxt = 8'h00;
    if (bus_req_in.rd)
    begin
      case (bus_req_in.addr)
        `STC_OFS_COUNT_LO: rdata_nxt = count_r[7:0];
        `STC_OFS_COUNT_HI: rdata_nxt = count_r[15:8];
        `STC_OFS_CTRL:     rdata_nxt = ctrl_r;
        `STC_OFS_GATE:     rdata_nxt = gate_rd;
        default:           rdata_nxt = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Control registers.
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      ctrl_r <= `STC_CTRL_RST;
      gate_r <= `STC_GATE_RST;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_r <= bus_req_in.wdata & `STC_CTRL_WR_MASK;
      if (wr_gate)
        gate_r <= bus_req_in.wdata & `STC_GATE_WR_MASK;
    end
  end

  // ----------------------------------------------------------------------
  // Counter, prescaler, divider and arming state.
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      count_r      <= `STC_COUNT_RST;
      presc_r      <= '0;
      div_r        <= '0;
      pin_rise_d_r <= 1'b0;
      arm_r        <= ST_OFF;
    end
    else
    begin
      count_r      <= count_nxt;
      presc_r      <= presc_nxt;
      div_r        <= div_r + DIV_W'(1);
      pin_rise_d_r <= pin_rise;
      arm_r        <= arm_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rdata_r <= 8'h00;
      ovf_r   <= 1'b0;
    end
    else
    begin
      rdata_r <= rdata_nxt;
      ovf_r   <= wraps & ~wr_cnt;
    end
  end

  // Read data stand for the one cycle after the read strobe.
  assign rdata_out    = rdata_r;
  assign count_out    = count_r;
  assign overflow_out = ovf_r;

  // Level showing that counting is enabled and, in pin mode, armed.
  assign counting_out = count_en & (~pin_mode | (arm_r == ST_ARMED));

endmodule : stc_timer

// ---- verification/stc_pin_source.sv ----
/*
  Behavioural model of the source that drives the external count pin.
  Assumes the bench sets the idle level and asks for bursts of pulses.
*/
`timescale 1ns/1ps

module stc_pin_source (
  input  wire logic       clk_sys_in,
  input  wire logic       go_in,
  input  wire logic [7:0] edges_in,
  input  wire logic       level_in,
  input  wire logic [3:0] half_in,
  output logic            pin_out,
  output logic            busy_out
);
  // --------------------------------------------------------------------
  // Pulse generator.
  // --------------------------------------------------------------------
  // Each pulse falls first and then rises, so every rise has a fall before it.
  initial
  begin
    pin_out = 1'b1;
    busy_out = 1'b0;
    forever
    begin
      @(posedge clk_sys_in);
      if (go_in)
      begin
        busy_out <= 1'b1;
        repeat (edges_in)
        begin
          pin_out <= 1'b0;
          repeat (half_in) @(posedge clk_sys_in);
          pin_out <= 1'b1;
          repeat (half_in) @(posedge clk_sys_in);
        end
        busy_out <= 1'b0;
      end
      else
        pin_out <= level_in;
    end
  end
endmodule : stc_pin_source

// ---- verification/stc_timer_monitor.sv ----
/*
  Port checker of the timer/counter: register port and count rate.
  Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps

module stc_timer_monitor #(
  parameter int COUNT_W = 16,
  parameter int PRESC_W = 2
) (
  input wire logic                  clk_sys_in,
  input wire logic                  resetn_in,
  input wire stc_pkg::stc_bus_req_s bus_req_in,
  input wire logic [7:0]            rdata_out,
  input wire logic [COUNT_W-1:0]    count_out,
  input wire logic                  overflow_out,
  input wire logic                  counting_out
);
  import stc_pkg::*;
  // --------------------------------------------------------------------
  // Helper logic and assertions.
  // --------------------------------------------------------------------
  logic [7:0] ctrl_r;
  wire  [7:0] cnt_lo = count_out[7:0];
  wire  [7:0] cnt_hi = count_out[15:8];
  wire  [7:0] wd     = bus_req_in.wdata;
  wire        quiet  = counting_out && !bus_req_in.wr && ctrl_r[5:4] == 2'h0;

  // Shadow of the control byte, so that the count rate can be predicted.
  always_ff @(posedge clk_sys_in or negedge resetn_in)
    if (!resetn_in)
      ctrl_r <= 8'h00;
    else if (bus_req_in.wr && bus_req_in.addr == 3'h2)
      ctrl_r <= bus_req_in.wdata;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);

  rd_lo_data_a: assert property (
    bus_req_in.rd && bus_req_in.addr == 3'h0 |=> rdata_out == $past(cnt_lo)) else $error("low byte read wrong");
  rd_hi_data_a: assert property (
    bus_req_in.rd && bus_req_in.addr == 3'h1 |=> rdata_out == $past(cnt_hi)) else $error("high byte read wrong");
  rd_idle_zero_a: assert property (
    !(bus_req_in.rd && !bus_req_in.addr[2]) |=> rdata_out == 8'h00) else $error("read data not zero");
  wr_lo_now_a: assert property (
    bus_req_in.wr && bus_req_in.addr == 3'h0 |=> cnt_lo == $past(wd)) else $error("low byte write late");
  wr_hi_now_a: assert property (
    bus_req_in.wr && bus_req_in.addr == 3'h1 |=> cnt_hi == $past(wd)) else $error("high byte write late");
  stopped_hold_a: assert property (
    !counting_out && !bus_req_in.wr |=> $stable(count_out)) else $error("count moved while stopped");
  sys_every_a: assert property (
    quiet && ctrl_r[7:6] == 2'h1 |=> count_out - $past(count_out) == 16'h0001) else $error("system rate wrong");
  div_four_a: assert property (
    (quiet && ctrl_r[7:6] == 2'h0) [*5] |-> count_out - $past(count_out, 4) == 16'h0001)
    else $error("instruction rate wrong");

  wrap_c: cover property (overflow_out);
  pin_c: cover property (counting_out && ctrl_r[7:6] == 2'h2);
  unmapped_c: cover property (bus_req_in.rd && bus_req_in.addr[2]);
endmodule : stc_timer_monitor

bind stc_timer stc_timer_monitor #(.COUNT_W(COUNT_W), .PRESC_W(PRESC_W)) i_mon (
  .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .bus_req_in(bus_req_in), .rdata_out(rdata_out),
  .count_out(count_out), .overflow_out(overflow_out), .counting_out(counting_out));

// ---- verification/stc_timer_tb.sv ----
/*
  Self-checking bench of the timer/counter: register tasks and directed tests.
  Assumes the package, the design, the pin source and the checker are compiled.
*/
`timescale 1ns/1ps

module stc_timer_tb;
  import stc_pkg::*;
  // --------------------------------------------------------------------
  // Stimulus, instances and tasks.
  // --------------------------------------------------------------------
  logic         clk_sys_in = 1'b0;
  logic         resetn_in  = 1'b0;
  logic         gate_pin   = 1'b0;
  logic         cmp        = 1'b0;
  logic         slow       = 1'b0;
  logic         go         = 1'b0;
  logic         lvl        = 1'b1;
  logic [7:0]   n_edges    = 8'h00;
  logic [3:0]   half       = 4'h2;
  stc_bus_req_s req        = '0;
  logic [7:0]   rdata;
  logic [15:0]  count;
  logic [15:0]  hold;
  logic         pin, busy, overflow, counting;
  int           error_cnt = 0, cmp_count = 0, ovf_cnt = 0;

  // The clock toggles every half period; overflow pulses are tallied.
  always #20 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) if (overflow === 1'b1) ovf_cnt++;

  stc_timer i_dut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .bus_req_in(req), .rdata_out(rdata),
    .external_count_input_in(pin), .gate_input_pin_in(gate_pin), .comparator_in(cmp),
    .slow_internal_oscillator_in(slow), .count_out(count), .overflow_out(overflow), .counting_out(counting));
  stc_pin_source i_src (.clk_sys_in(clk_sys_in), .go_in(go), .edges_in(n_edges), .level_in(lvl),
    .half_in(half), .pin_out(pin), .busy_out(busy));

  task conclude;
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude

  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task cyc(input int k);
    repeat (k) @(posedge clk_sys_in);
  endtask : cyc

  task cnt(input logic [15:0] e);
    #1 chk("count", count, e);
  endtask : cnt

  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    req <= stc_bus_req_s'{a, d, 1'b1, 1'b0};
    @(posedge clk_sys_in);
    req <= '0;
  endtask : wr

  task rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_sys_in);
    req <= stc_bus_req_s'{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_sys_in);
    req <= '0;
    #1 chk("read data", {8'h00, rdata}, {8'h00, e});
  endtask : rd

  // Loads the count with the counter stopped, then writes the control byte.
  task start(input logic [7:0] c, input logic [15:0] v);
    wr(3'h2, c & 8'hFE);
    wr(3'h0, v[7:0]);
    wr(3'h1, v[15:8]);
    wr(3'h2, c);
  endtask : start

  task pulses(input logic [7:0] k, input logic [3:0] h);
    @(posedge clk_sys_in);
    n_edges <= k;
    half <= h;
    go <= 1'b1;
    @(posedge clk_sys_in);
    go <= 1'b0;
    @(posedge clk_sys_in);
    // A source that never finishes is caught by the watchdog.
    while (busy !== 1'b0)
      @(posedge clk_sys_in);
    cyc(6);
  endtask : pulses

  // Watchdog sized well above the thousand or so cycles that the tests take.
  initial
  begin
    cyc(20000);
    error_cnt++;
    conclude();
  end

  // Main sequence.
  initial
  begin
    cyc(8);
    resetn_in <= 1'b1;
    rd(3'h2, 8'h00);
    rd(3'h3, 8'h00);
    wr(3'h0, 8'h5A);
    wr(3'h1, 8'hC3);
    rd(3'h0, 8'h5A);
    rd(3'h1, 8'hC3);
    // A write to an unmapped offset must leave every register alone.
    wr(3'h6, 8'hFF);
    rd(3'h5, 8'h00);
    rd(3'h2, 8'h00);
    wr(3'h2, 8'hFF);
    rd(3'h2, 8'hFD);
    wr(3'h2, 8'h00);
    wr(3'h3, 8'hFF);
    rd(3'h3, 8'hC1);
    wr(3'h3, 8'h00);
    start(8'h40, 16'h1234);
    cyc(20);
    cnt(16'h1234);
    // Forty clocks hold exactly ten instruction ticks, whatever the divider phase.
    for (int m = 0; m < 2; m++)
    begin
      start({m[1:0], 6'h09}, 16'h0000);
      cyc(40);
      cnt(m == 1 ? 16'h0028 : 16'h000A);
    end
    ovf_cnt = 0;
    start(8'h49, 16'hFFF0);
    cyc(20);
    cnt(16'h0004);
    chk("overflow", ovf_cnt[15:0], 16'h0001);
    for (int p = 0; p < 4; p++)
    begin
      start({2'h3, p[1:0], 4'h1}, 16'h0000);
      repeat (16)
      begin
        cyc(4);
        slow <= 1'b1;
        cyc(4);
        slow <= 1'b0;
      end
      cyc(6);
      cnt(16'h0010 >> p);
    end
    wr(3'h3, 8'h80);
    start(8'h41, 16'h0000);
    cyc(20);
    cnt(16'h0000);
    chk("counting", {15'h0000, counting}, 16'h0000);
    // The gate pin takes two stages to reach the gate, then every clock counts.
    gate_pin <= 1'b1;
    cyc(20);
    cnt(16'h0012);
    wr(3'h3, 8'hC1);
    cmp <= 1'b1;
    cyc(5);
    hold = count;
    cyc(20);
    cnt(hold);
    // The gate is switched off again so that the pin tests run ungated.
    wr(3'h3, 8'h00);
    start(8'h81, 16'h0000);
    cyc(10);
    cnt(16'h0000);
    chk("counting", {15'h0000, counting}, 16'h0000);
    pulses(8'h05, 4'h7);
    cnt(16'h0005);
    chk("counting", {15'h0000, counting}, 16'h0001);
    wr(3'h2, 8'h85);
    lvl <= 1'b0;
    cyc(5);
    wr(3'h0, 8'h00);
    lvl <= 1'b1;
    cyc(8);
    cnt(16'h0000);
    pulses(8'h03, 4'h2);
    cnt(16'h0003);
    wr(3'h2, 8'h84);
    lvl <= 1'b0;
    cyc(5);
    wr(3'h2, 8'h85);
    lvl <= 1'b1;
    cyc(8);
    cnt(16'h0003);
    pulses(8'h02, 4'h2);
    cnt(16'h0005);
    conclude();
  end
endmodule : stc_timer_tb
